// ===== gdsp_top.sv
// Gate drive control for two full bridges with short to ground protection.
// Assumes an APB master on CORE_CLK; gate sense inputs synchronous.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "gdsp_defines.svh"

// How it works
// RULE1: Low-side slope 00/01 minimum, 10 medium, 11 maximum current.
// RULE2: High-side slope 00 min, 01 min+TC, 10 medium+TC, 11 maximum.
// RULE3: Opposite transistor waits until sensed gate shows counterpart discharged.
// RULE4: Disable input high keeps all bridge transistors off.
// RULE5: Off-time setting zero switches all bridge transistors off.
// RULE6: Short turns bridge off, ends chopper cycle, increments counter.
// RULE7: Counter decrements on each coil polarity change.
// RULE8: Counter at 3 latches bridges off until disable then enable.
// RULE9: Per-coil short flags set on persistence, cleared when disabled.
// RULE10: High-side coil voltage low at delay expiry is overload.
// RULE11: Detect-off bit 1 disables short detection, 0 enables.
// RULE12: Delay codes 00/01/10/11 give 3.2/1.6/1.2/0.8 microseconds.
// RULE13: Software picks a delay just above the switching slope time.
// RULE14: Temperature-compensated settings add one current step on warning.
// RULE15: Counter never below zero, clears when driver disabled.
module gdsp_top (
  input  wire logic                   CORE_CLK,
  input  wire logic                   NRST,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [11:0]            PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic                   DRIVE_DISABLE_N_INPUT,
  input  wire logic                   OVERTEMP_WARNING_FLAG,
  input  wire logic                   PHASE_A,
  input  wire logic                   PHASE_B,
  input  wire logic                   DRIVE_A,
  input  wire logic                   DRIVE_B,
  input  wire gdsp_pkg::gdsp_sense_t  SENSE_A1,
  input  wire gdsp_pkg::gdsp_sense_t  SENSE_A2,
  input  wire gdsp_pkg::gdsp_sense_t  SENSE_B1,
  input  wire gdsp_pkg::gdsp_sense_t  SENSE_B2,
  output gdsp_pkg::gdsp_gate_t        GATE_A1,
  output gdsp_pkg::gdsp_gate_t        GATE_A2,
  output gdsp_pkg::gdsp_gate_t        GATE_B1,
  output gdsp_pkg::gdsp_gate_t        GATE_B2,
  output gdsp_pkg::gdsp_cur_t         LOW_SIDE_CURRENT,
  output gdsp_pkg::gdsp_cur_t         HIGH_SIDE_CURRENT,
  output logic                        CHOP_END_A,
  output logic                        CHOP_END_B,
  output logic                        IRQ
);

  // ============================================================
  // Timing constants
  localparam logic [9:0] DLY_00_CYC = 10'(`GDSP_NS_TO_CYC(`GDSP_DLY_00_NS));
  localparam logic [9:0] DLY_01_CYC = 10'(`GDSP_NS_TO_CYC(`GDSP_DLY_01_NS));
  localparam logic [9:0] DLY_10_CYC = 10'(`GDSP_NS_TO_CYC(`GDSP_DLY_10_NS));
  localparam logic [9:0] DLY_11_CYC = 10'(`GDSP_NS_TO_CYC(`GDSP_DLY_11_NS));

  logic [31:0] ctrl_reg;
  logic [4:0]  status_reg;
  logic [4:0]  irq_en_reg;
  logic [4:0]  irq_evt;
  logic [4:0]  irq_clr;
  logic [31:0] rdata_next;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [3:0]  off_time_setting;
  logic [1:0]  low_side_slope;
  logic [1:0]  high_side_slope;
  logic        short_detect_off;
  logic [1:0]  short_detect_delay;
  logic        enable;
  logic        enable_reg;
  logic [9:0]  dly_cyc;
  logic        evt_a;
  logic        evt_b;
  logic        latch_a;
  logic        latch_b;
  logic [1:0]  cnt_a;
  logic [1:0]  cnt_b;
  logic        short_flag_coil_a;
  logic        short_flag_coil_b;

  // ============================================================
  // Decode helpers
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = a == off;
  endfunction

  function automatic logic [9:0] delay_of(input logic [1:0] code);
    case (code)
      2'h0:    delay_of = DLY_00_CYC; // RULE12
      2'h1:    delay_of = DLY_01_CYC;
      2'h2:    delay_of = DLY_10_CYC;
      default: delay_of = DLY_11_CYC;
    endcase
  endfunction

  assign off_time_setting   = ctrl_reg[`GDSP_CTRL_OFF_TIME_SETTING_MSB:`GDSP_CTRL_OFF_TIME_SETTING_LSB];
  assign low_side_slope     = ctrl_reg[`GDSP_CTRL_LOW_SIDE_SLOPE_LSB +: 2];
  assign high_side_slope    = ctrl_reg[`GDSP_CTRL_HIGH_SIDE_SLOPE_LSB +: 2];
  assign short_detect_off   = ctrl_reg[`GDSP_CTRL_DIS_BIT];
  assign short_detect_delay = ctrl_reg[`GDSP_CTRL_DLY_LSB +: 2];
  assign dly_cyc            = delay_of(short_detect_delay);

  // Either disable path frees the motor; off time zero acts like the pin
  assign enable = !DRIVE_DISABLE_N_INPUT && off_time_setting != 4'h0; // RULE4 RULE5

  // ============================================================
  // APB slave, zero wait states
  assign PREADY  = 1'b1;
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && !PENABLE && !PWRITE;
  assign hit     = addr_is(PADDR, `GDSP_OFF_CTRL) || addr_is(PADDR, `GDSP_OFF_STATUS)
                || addr_is(PADDR, `GDSP_OFF_IRQ_EN) || addr_is(PADDR, `GDSP_OFF_IRQ_CLR)
                || addr_is(PADDR, `GDSP_OFF_SHORTCNT);
  assign PSLVERR = PSEL && PENABLE && !hit;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_reg <= `GDSP_CTRL_RESET;
    end else if (wr_en && addr_is(PADDR, `GDSP_OFF_CTRL)) begin
      ctrl_reg <= {21'h00_0000, PWDATA[10:0]};
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_en_reg <= 5'h00;
    end else if (wr_en && addr_is(PADDR, `GDSP_OFF_IRQ_EN)) begin
      irq_en_reg <= PWDATA[4:0];
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (addr_is(PADDR, `GDSP_OFF_CTRL)) begin
      rdata_next = ctrl_reg;
    end else if (addr_is(PADDR, `GDSP_OFF_STATUS)) begin
      rdata_next = {27'h000_0000, status_reg};
    end else if (addr_is(PADDR, `GDSP_OFF_IRQ_EN)) begin
      rdata_next = {27'h000_0000, irq_en_reg};
    end else if (addr_is(PADDR, `GDSP_OFF_SHORTCNT)) begin
      rdata_next = {28'h000_0000, cnt_b, cnt_a};
    end
  end

  // Read data registered in setup, stable through access phase
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_en) begin
      PRDATA <= rdata_next;
    end
  end

  // ============================================================
  // Slope selection
  always_comb begin
    case (low_side_slope)
      2'h2:    LOW_SIDE_CURRENT = gdsp_pkg::GDSP_I_MED; // RULE1
      2'h3:    LOW_SIDE_CURRENT = gdsp_pkg::GDSP_I_MAX;
      default: LOW_SIDE_CURRENT = gdsp_pkg::GDSP_I_MIN;
    endcase
  end

  // Compensated modes step up one level at the warning threshold
  always_comb begin
    case (high_side_slope)
      2'h1: HIGH_SIDE_CURRENT = OVERTEMP_WARNING_FLAG ? gdsp_pkg::GDSP_I_MED
                                                      : gdsp_pkg::GDSP_I_MIN; // RULE2 RULE14
      2'h2: HIGH_SIDE_CURRENT = OVERTEMP_WARNING_FLAG ? gdsp_pkg::GDSP_I_MAX
                                                      : gdsp_pkg::GDSP_I_MED; // RULE2 RULE14
      2'h3:    HIGH_SIDE_CURRENT = gdsp_pkg::GDSP_I_MAX;
      default: HIGH_SIDE_CURRENT = gdsp_pkg::GDSP_I_MIN;
    endcase
  end

  // ============================================================
  // Coils
  gdsp_coil u_coil_a (
    .clk       (CORE_CLK),
    .nrst      (NRST),
    .enable    (enable),
    .det_on    (!short_detect_off),
    .dly_cyc   (dly_cyc),
    .phase     (PHASE_A),
    .drive     (DRIVE_A),
    .sense_p   (SENSE_A1),
    .sense_n   (SENSE_A2),
    .gate_p    (GATE_A1),
    .gate_n    (GATE_A2),
    .short_evt (evt_a),
    .chop_end  (CHOP_END_A),
    .latched   (latch_a),
    .count     (cnt_a)
  );

  gdsp_coil u_coil_b (
    .clk       (CORE_CLK),
    .nrst      (NRST),
    .enable    (enable),
    .det_on    (!short_detect_off),
    .dly_cyc   (dly_cyc),
    .phase     (PHASE_B),
    .drive     (DRIVE_B),
    .sense_p   (SENSE_B1),
    .sense_n   (SENSE_B2),
    .gate_p    (GATE_B1),
    .gate_n    (GATE_B2),
    .short_evt (evt_b),
    .chop_end  (CHOP_END_B),
    .latched   (latch_b),
    .count     (cnt_b)
  );

  // Persistent short: counter above one means repeats across cycles
  assign short_flag_coil_a = cnt_a >= 2'h2;
  assign short_flag_coil_b = cnt_b >= 2'h2;

  // ============================================================
  // Status and interrupt; set wins over clear
  assign irq_evt = {evt_b, evt_a, latch_a || latch_b, short_flag_coil_b, short_flag_coil_a};
  assign irq_clr = (wr_en && addr_is(PADDR, `GDSP_OFF_IRQ_CLR)) ? PWDATA[4:0] : 5'h00;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      enable_reg <= 1'b0;
    end else begin
      enable_reg <= enable;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_st
      always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
          status_reg[i] <= 1'b0;
        end else if (irq_evt[i]) begin
          status_reg[i] <= 1'b1; // RULE9
        end else if (!enable || irq_clr[i]) begin
          status_reg[i] <= 1'b0; // RULE9
        end
      end
    end
  endgenerate

  assign IRQ = |(status_reg & irq_en_reg);

  a_flag_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !enable && !enable_reg ##1 !enable |-> status_reg[1:0] == 2'b00) // RULE9
    else $error("short flags not cleared while disabled");
  a_gates_off: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $past(!enable) |-> {GATE_A1, GATE_A2, GATE_B1, GATE_B2} == 8'h00) // RULE4
    else $error("gate on while disabled");
  a_off_time_setting_zero: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    off_time_setting == 4'h0 ##1 off_time_setting == 4'h0
      |-> {GATE_A1, GATE_A2, GATE_B1, GATE_B2} == 8'h00) // RULE5
    else $error("gate on with zero off time");
  a_detect_off: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    short_detect_off |-> !evt_a && !evt_b) // RULE11
    else $error("detection while disabled");
  a_delay_code: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    short_detect_delay == 2'h3 |-> dly_cyc == 10'd200) // RULE12
    else $error("delay code mismatch");
  a_slope_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    low_side_slope == 2'h1 |-> LOW_SIDE_CURRENT == gdsp_pkg::GDSP_I_MIN) // RULE1
    else $error("low side slope mismatch");
  a_slope_tc: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    high_side_slope == 2'h2 && OVERTEMP_WARNING_FLAG
      |-> HIGH_SIDE_CURRENT == gdsp_pkg::GDSP_I_MAX) // RULE14
    else $error("compensation step missing");
  a_slope_high: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    high_side_slope == 2'h0 |-> HIGH_SIDE_CURRENT == gdsp_pkg::GDSP_I_MIN) // RULE2
    else $error("high side slope mismatch");
  a_cnt_floor: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !enable |=> cnt_a == 2'h0 && cnt_b == 2'h0) // RULE15
    else $error("counter not cleared");

endmodule

// ===== gdsp_defines.svh
// Offsets, field positions, reset values and timing counts of the gate drive block.
// Assumes a 250 MHz core clock; included by bare name.
`ifndef GDSP_DEFINES_SVH
`define GDSP_DEFINES_SVH

// ============================================================
// Register offsets (byte addresses)
`define GDSP_OFF_CTRL      12'h000
`define GDSP_OFF_STATUS    12'h004
`define GDSP_OFF_IRQ_EN    12'h008
`define GDSP_OFF_IRQ_CLR   12'h00C
`define GDSP_OFF_SHORTCNT  12'h010

// ============================================================
// Control fields
`define GDSP_CTRL_OFF_TIME_SETTING_LSB  0
`define GDSP_CTRL_OFF_TIME_SETTING_MSB  3
`define GDSP_CTRL_LOW_SIDE_SLOPE_LSB  4
`define GDSP_CTRL_HIGH_SIDE_SLOPE_LSB  6
`define GDSP_CTRL_DIS_BIT   8
`define GDSP_CTRL_DLY_LSB   9
`define GDSP_CTRL_RESET     32'h0000_0000

// ============================================================
// Status bits
`define GDSP_ST_SHORT_A   0
`define GDSP_ST_SHORT_B   1
`define GDSP_ST_LATCH     2
`define GDSP_ST_EVT_A     3
`define GDSP_ST_EVT_B     4

// ============================================================
// Timing
`define GDSP_CLK_MHZ        250
`define GDSP_DLY_00_NS      3200
`define GDSP_DLY_01_NS      1600
`define GDSP_DLY_10_NS      1200
`define GDSP_DLY_11_NS      800
`define GDSP_NS_TO_CYC(ns)  (((ns) * `GDSP_CLK_MHZ + 999) / 1000)
`define GDSP_SHORT_LIMIT    2'h3

`endif

// ===== gdsp_pkg.sv
// Types shared by the gate drive block.
// Assumes the defines header for numeric constants.
package gdsp_pkg;

  // ============================================================
  // Drive strength
  typedef enum logic [1:0] {
    GDSP_I_MIN = 2'h0,
    GDSP_I_MED = 2'h1,
    GDSP_I_MAX = 2'h2
  } gdsp_cur_t;

  // ============================================================
  // Half bridge sequencing, Gray along the path except the steps between OFF and WAIT
  typedef enum logic [1:0] {
    GDSP_HB_OFF  = 2'b00,
    GDSP_HB_HIGH = 2'b01,
    GDSP_HB_WAIT = 2'b11,
    GDSP_HB_LOW  = 2'b10
  } gdsp_hb_t;

  typedef struct packed {
    logic high_on;
    logic low_on;
  } gdsp_gate_t;

  typedef struct packed {
    logic high_discharged;
    logic low_discharged;
    logic coil_high;
  } gdsp_sense_t;

endpackage

// ===== gdsp_coil.sv
// One coil: two half bridges, short detection and short counter.
// Assumes gate sense and coil level inputs synchronous to the core clock.
`timescale 1ns/1ns
`include "gdsp_defines.svh"

module gdsp_coil (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   enable,
  input  wire logic                   det_on,
  input  wire logic [9:0]             dly_cyc,
  input  wire logic                   phase,
  input  wire logic                   drive,
  input  wire gdsp_pkg::gdsp_sense_t  sense_p,
  input  wire gdsp_pkg::gdsp_sense_t  sense_n,
  output gdsp_pkg::gdsp_gate_t        gate_p,
  output gdsp_pkg::gdsp_gate_t        gate_n,
  output logic                        short_evt,
  output logic                        chop_end,
  output logic                        latched,
  output logic [1:0]                  count
);

  gdsp_pkg::gdsp_hb_t   st_reg [2];
  gdsp_pkg::gdsp_sense_t sn [2];
  gdsp_pkg::gdsp_gate_t  gt [2];
  logic [9:0]           tmr_reg;
  logic                 phase_reg;
  logic [1:0]           cnt_reg;
  logic                 trip_reg;
  logic                 hs_on;
  logic                 hs_ok;
  logic                 off_all;

  assign sn[0]   = sense_p;
  assign sn[1]   = sense_n;
  assign off_all = !enable || trip_reg || cnt_reg == `GDSP_SHORT_LIMIT;

  // ============================================================
  // Break-before-make per half bridge
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_hb
      logic want_high;
      assign want_high = drive && ((g == 0) ? phase : !phase);
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          st_reg[g] <= gdsp_pkg::GDSP_HB_OFF;
        end else if (off_all) begin
          st_reg[g] <= gdsp_pkg::GDSP_HB_OFF; // RULE4 RULE5 RULE6 RULE8
        end else begin
          case (st_reg[g])
            gdsp_pkg::GDSP_HB_OFF:
              st_reg[g] <= gdsp_pkg::GDSP_HB_WAIT;
            gdsp_pkg::GDSP_HB_WAIT: begin
              if (want_high && sn[g].low_discharged) begin
                st_reg[g] <= gdsp_pkg::GDSP_HB_HIGH; // RULE3
              end else if (!want_high && sn[g].high_discharged) begin
                st_reg[g] <= gdsp_pkg::GDSP_HB_LOW; // RULE3
              end
            end
            gdsp_pkg::GDSP_HB_HIGH:
              if (!want_high) st_reg[g] <= gdsp_pkg::GDSP_HB_WAIT;
            gdsp_pkg::GDSP_HB_LOW:
              if (want_high) st_reg[g] <= gdsp_pkg::GDSP_HB_WAIT;
            default:
              st_reg[g] <= gdsp_pkg::GDSP_HB_OFF;
          endcase
        end
      end
      assign gt[g].high_on = st_reg[g] == gdsp_pkg::GDSP_HB_HIGH;
      assign gt[g].low_on  = st_reg[g] == gdsp_pkg::GDSP_HB_LOW;
    end
  endgenerate

  assign gate_p = gt[0];
  assign gate_n = gt[1];

  // ============================================================
  // Short detection timer over the high-side on phase
  assign hs_on = gt[0].high_on || gt[1].high_on;
  assign hs_ok = gt[0].high_on ? sense_p.coil_high : sense_n.coil_high;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmr_reg <= 10'h000;
    end else if (!hs_on) begin
      tmr_reg <= 10'h000;
    end else if (tmr_reg != 10'h3FF) begin
      tmr_reg <= tmr_reg + 10'h001;
    end
  end

  // Level still low when delay expires means overload
  assign short_evt = det_on && hs_on && !hs_ok && (tmr_reg == dly_cyc); // RULE10 RULE11
  assign chop_end  = short_evt; // RULE6

  // Bridge stays off for the rest of this chopper cycle; repeats can reach the latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trip_reg <= 1'b0;
    end else if (!enable || !drive || phase != phase_reg) begin
      trip_reg <= 1'b0;
    end else if (short_evt) begin
      trip_reg <= 1'b1; // RULE6
    end
  end

  // ============================================================
  // Short counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 1'b0;
      cnt_reg   <= 2'h0;
    end else begin
      phase_reg <= phase;
      if (!enable) begin
        cnt_reg <= 2'h0; // RULE15
      end else if (cnt_reg == `GDSP_SHORT_LIMIT) begin
        cnt_reg <= cnt_reg; // RULE8
      end else if (short_evt) begin
        cnt_reg <= cnt_reg + 2'h1; // RULE6
      end else if (phase != phase_reg && cnt_reg != 2'h0) begin
        cnt_reg <= cnt_reg - 2'h1; // RULE7 RULE15
      end
    end
  end

  assign latched = cnt_reg == `GDSP_SHORT_LIMIT;
  assign count   = cnt_reg;

  a_counter_step: assert property (@(posedge clk) disable iff (!nrst)
    enable && short_evt && cnt_reg != 2'h3 |=> cnt_reg == $past(cnt_reg) + 2'h1) // RULE6
    else $error("short counter did not step");
  a_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
    latched && enable |=> latched && !gt[0].high_on && !gt[1].high_on) // RULE8
    else $error("latched bridge drove");
  a_no_cross: assert property (@(posedge clk) disable iff (!nrst)
    !(gt[0].high_on && gt[0].low_on) && !(gt[1].high_on && gt[1].low_on)) // RULE3
    else $error("cross conduction");

endmodule

// ===== gdsp_bridge_model.sv
// Behavioural model of one external half bridge and its sense lines.
// Assumes gate commands from the block, sampled on the core clock.
`timescale 1ns/1ns

module gdsp_bridge_model (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire gdsp_pkg::gdsp_gate_t  gate,
  input  wire logic                  shorted,
  output gdsp_pkg::gdsp_sense_t      sense
);
  // ============================================================
  // Gate charge history, three cycles of slope
  logic [2:0] h_reg;
  logic [2:0] l_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      h_reg <= 3'h0;
      l_reg <= 3'h0;
    end else begin
      h_reg <= {h_reg[1:0], gate.high_on};
      l_reg <= {l_reg[1:0], gate.low_on};
    end
  end

  // Discharged only once the whole slope has passed
  assign sense.high_discharged = (h_reg == 3'h0) && !gate.high_on;
  assign sense.low_discharged  = (l_reg == 3'h0) && !gate.low_on;
  // Shorted coil never reaches the detection level
  assign sense.coil_high = gate.high_on && h_reg[2] && !shorted;
endmodule

// ===== gdsp_top_test.sv
// Self-checking testbench of the gate drive block.
// Assumes the design files and the bridge model compiled before it.
`timescale 1ns/1ns
`include "gdsp_defines.svh"

module gdsp_top_test;
  logic CORE_CLK, NRST, PSEL, PENABLE, PWRITE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic PREADY, PSLVERR, DRIVE_DISABLE_N_INPUT, OVERTEMP_WARNING_FLAG;
  logic PHASE_A, PHASE_B, DRIVE_A, DRIVE_B, CHOP_END_A, CHOP_END_B, IRQ;
  logic short_a;
  gdsp_pkg::gdsp_sense_t s[4];
  gdsp_pkg::gdsp_gate_t  g[4];
  gdsp_pkg::gdsp_cur_t   LOW_SIDE_CURRENT, HIGH_SIDE_CURRENT;
  int n_mismatch, comparisons, n_chop, cyc;
  logic [31:0] rd;
  logic err;

  gdsp_top gdsp_top_i (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DRIVE_DISABLE_N_INPUT(DRIVE_DISABLE_N_INPUT),
    .OVERTEMP_WARNING_FLAG(OVERTEMP_WARNING_FLAG), .PHASE_A(PHASE_A),
    .PHASE_B(PHASE_B), .DRIVE_A(DRIVE_A), .DRIVE_B(DRIVE_B),
    .SENSE_A1(s[0]), .SENSE_A2(s[1]), .SENSE_B1(s[2]), .SENSE_B2(s[3]),
    .GATE_A1(g[0]), .GATE_A2(g[1]), .GATE_B1(g[2]), .GATE_B2(g[3]),
    .LOW_SIDE_CURRENT(LOW_SIDE_CURRENT), .HIGH_SIDE_CURRENT(HIGH_SIDE_CURRENT),
    .CHOP_END_A(CHOP_END_A), .CHOP_END_B(CHOP_END_B), .IRQ(IRQ));

  // ============================================================
  // Far side bridges, only coil A's first half bridge can short
  for (genvar i = 0; i < 4; i++) begin : gen_br
    gdsp_bridge_model gdsp_bridge_model_i (
      .clk(CORE_CLK), .nrst(NRST), .gate(g[i]),
      .shorted((i == 0) ? short_a : 1'b0), .sense(s[i]));
  end

  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  // ============================================================
  // Compare, report, close
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; waits for PREADY, never assumes a latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  function automatic logic [31:0] ctrl(input int code, input logic dis);
    return 32'h0000_0001 | (code << 9) | (32'(dis) << 8);
  endfunction

  // ============================================================
  // Cross-conduction watch on every half bridge
  always @(posedge CORE_CLK) begin
    if (NRST && short_a !== 1'bx) begin
      for (int i = 0; i < 4; i++) begin
        if (g[i].high_on === 1'b1 && s[i].low_discharged !== 1'b1) chk(1, 0);
        if (g[i].low_on === 1'b1 && s[i].high_discharged !== 1'b1) chk(1, 0);
      end
    end
    if (CHOP_END_A === 1'b1) n_chop++;
    if (CHOP_END_B === 1'b1) chk(1, 0);
  end

  initial begin
    repeat (20000) @(posedge CORE_CLK);
    n_mismatch++;
    complete_run;
  end

  // ============================================================
  // Test sequence
  initial begin
    int lo [4] = '{0, 0, 1, 2};
    int hi [2][4] = '{'{0, 0, 1, 2}, '{0, 1, 2, 2}};
    int dly [4] = '{800, 400, 300, 200};
    NRST = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
    PADDR = 12'h000; PWDATA = 32'h0000_0000; DRIVE_DISABLE_N_INPUT = 1'b0;
    OVERTEMP_WARNING_FLAG = 1'b0; PHASE_A = 1'b0; PHASE_B = 1'b0;
    DRIVE_A = 1'b0; DRIVE_B = 1'b1; short_a = 1'b0;
    n_mismatch = 0; comparisons = 0; n_chop = 0;
    repeat (10) @(posedge CORE_CLK);
    NRST <= 1'b1;
    DRIVE_A <= 1'b1;
    repeat (5) @(posedge CORE_CLK);
    chk(32'({g[0], g[1], g[2], g[3]}), 0);
    apb(0, `GDSP_OFF_CTRL, 0);
    chk(rd, `GDSP_CTRL_RESET);
    apb(0, 12'h020, 0);
    chk({rd[30:0], err}, 32'h0000_0001);
    // Slope codes, without and with temperature warning
    for (int w = 0; w < 2; w++) begin
      OVERTEMP_WARNING_FLAG <= w[0];
      for (int c = 0; c < 4; c++) begin
        apb(1, `GDSP_OFF_CTRL, (c << 4) | (c << 6));
        @(posedge CORE_CLK);
        chk(32'(LOW_SIDE_CURRENT), lo[c]);
        chk(32'(HIGH_SIDE_CURRENT), hi[w][c]);
      end
    end
    OVERTEMP_WARNING_FLAG <= 1'b0;
    short_a <= 1'b1;
    apb(1, `GDSP_OFF_IRQ_EN, 32'h0000_0008);
    // Detection delay per code, timed from high side turn-on
    for (int c = 3; c >= 0; c--) begin
      apb(1, `GDSP_OFF_CTRL, ctrl(c, 0));
      repeat (20) @(posedge CORE_CLK);
      chk(32'({g[0], g[1]}), 32'h0000_0006);
      PHASE_A <= 1'b1;
      cyc = 0;
      while (g[0].high_on !== 1'b1 && cyc < 50) begin
        @(posedge CORE_CLK);
        cyc++;
      end
      cyc = 0;
      while (CHOP_END_A !== 1'b1 && cyc < 1000) begin
        @(posedge CORE_CLK);
        cyc++;
      end
      chk(32'(cyc >= dly[c] - 1 && cyc <= dly[c] + 3), 1);
      repeat (3) @(posedge CORE_CLK);
      chk(32'(g[0].high_on), 0);
      apb(0, `GDSP_OFF_SHORTCNT, 0);
      chk(rd & 32'h0000_0003, 1);
      chk(32'(IRQ), 1);
      PHASE_A <= 1'b0;
      repeat (10) @(posedge CORE_CLK);
      apb(0, `GDSP_OFF_SHORTCNT, 0);
      chk(rd & 32'h0000_0003, 0);
    end
    apb(0, `GDSP_OFF_STATUS, 0);
    chk(rd & 32'h0000_0018, 32'h0000_0008);
    apb(1, `GDSP_OFF_IRQ_EN, 0);
    @(posedge CORE_CLK);
    chk(32'(IRQ), 0);
    apb(1, `GDSP_OFF_IRQ_CLR, 32'h0000_0008);
    apb(0, `GDSP_OFF_STATUS, 0);
    chk(rd & 32'h0000_0008, 0);
    // Detection off: shorted coil runs on
    n_chop = 0;
    apb(1, `GDSP_OFF_CTRL, ctrl(3, 1));
    PHASE_A <= 1'b1;
    repeat (300) @(posedge CORE_CLK);
    chk(n_chop, 0);
    chk(32'(g[0].high_on), 1);
    short_a <= 1'b0;
    PHASE_A <= 1'b0;
    repeat (10) @(posedge CORE_CLK);
    apb(0, `GDSP_OFF_SHORTCNT, 0);
    chk(rd & 32'h0000_0003, 0);
    // Repeated shorts within one polarity latch the bridge off
    short_a <= 1'b1;
    PHASE_A <= 1'b1;
    apb(1, `GDSP_OFF_CTRL, ctrl(3, 0));
    repeat (3) begin
      DRIVE_A <= 1'b0;
      repeat (5) @(posedge CORE_CLK);
      DRIVE_A <= 1'b1;
      repeat (250) @(posedge CORE_CLK);
    end
    apb(0, `GDSP_OFF_SHORTCNT, 0);
    chk(rd & 32'h0000_0003, 3);
    apb(0, `GDSP_OFF_STATUS, 0);
    chk(rd & 32'h0000_0007, 32'h0000_0005);
    PHASE_A <= 1'b0;
    repeat (20) @(posedge CORE_CLK);
    chk(32'({g[0], g[1]}), 0);
    // Hardware disable, then software off time zero
    DRIVE_DISABLE_N_INPUT <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    chk(32'({g[0], g[1], g[2], g[3]}), 0);
    apb(0, `GDSP_OFF_STATUS, 0);
    chk(rd, 0);
    apb(0, `GDSP_OFF_SHORTCNT, 0);
    chk(rd, 0);
    DRIVE_DISABLE_N_INPUT <= 1'b0;
    apb(1, `GDSP_OFF_CTRL, 0);
    repeat (3) @(posedge CORE_CLK);
    chk(32'({g[0], g[1], g[2], g[3]}), 0);
    complete_run;
  end
endmodule
